/* File: src/smc_pkg.sv */
package smc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 125;     // mclk rate
    localparam int BOOT_TIME_US   = 500;     // longest boot sequence
    localparam int TON_EXTRA_US   = 1;       // 1 us, unused; the fixed part of the turn-on time is TON_EXTRA_MS (1 ms)
    localparam int TON_EXTRA_MS   = 1;
    localparam int BOOT_CYCLES    = BOOT_TIME_US * CLK_MHZ;
    localparam int TON_EXTRA_CYC  = TON_EXTRA_MS * 1000 * CLK_MHZ;
    localparam int TON_ODR_PERIODS = 2;      // whole sample periods in the turn-on time

    // ------------------------------------------------------------------
    // data format
    // ------------------------------------------------------------------
    localparam int RAW_W          = 16;      // front-end word, 1/1024 g per count
    localparam int OUT_W          = 12;      // reported sample width
    localparam int ODR_W          = 24;      // width of the sample period setting
    localparam logic [11:0] OUT_RESET = 12'h000;  // mid-range, zero acceleration
    localparam logic [15:0] OUT_MAX   = 16'h07FF;
    localparam logic [15:0] OUT_MIN   = 16'hF800;

    // full-scale range codes and their shift from 1024 counts per g
    localparam logic [1:0] RANGE_2G = 2'h0;  // 1024 counts per g
    localparam logic [1:0] RANGE_4G = 2'h1;  // 512 counts per g
    localparam logic [1:0] RANGE_8G = 2'h2;  // 256 counts per g

    // ------------------------------------------------------------------
    // reported system mode
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_WAKE    = 2'h1;
    localparam logic [1:0] MODE_SLEEP   = 2'h2;

    typedef enum logic [2:0] {
        SMC_OFF     = 3'b000,
        SMC_BOOT    = 3'b001,
        SMC_STANDBY = 3'b010,
        SMC_WAKE    = 3'b011,
        SMC_SLEEP   = 3'b100
    } smc_state_t;

endpackage

/* File: src/smc_mode_ctrl.sv */
`timescale 1ns/100ps
module smc_mode_ctrl #(
    parameter int BOOT_CYC = smc_pkg::BOOT_CYCLES,
    parameter int TON_CYC  = smc_pkg::TON_EXTRA_CYC
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // supply monitor pin (asynchronous)
    input  wire logic                          supply_ok,
    // mode control from the register block
    input  wire logic                          active_req,
    input  wire logic                          sleep_req,
    input  wire logic [1:0]                    range_sel,
    input  wire logic                          self_test_en,
    input  wire logic [smc_pkg::ODR_W-1:0]     odr_period,
    // analog front end
    input  wire logic signed [smc_pkg::RAW_W-1:0] accel_x,
    input  wire logic signed [smc_pkg::RAW_W-1:0] accel_y,
    input  wire logic signed [smc_pkg::RAW_W-1:0] accel_z,
    input  wire logic signed [smc_pkg::RAW_W-1:0] stim_x,
    input  wire logic signed [smc_pkg::RAW_W-1:0] stim_y,
    input  wire logic signed [smc_pkg::RAW_W-1:0] stim_z,
    // power and clock controls
    output logic                               analog_en,
    output logic                               sample_clk_en,
    output logic                               self_test_drive,
    output logic                               bus_enable,
    output logic                               scl_oe,
    output logic                               subset_reset,
    // status
    output logic [1:0]                         system_mode_state,
    output logic                               data_trusted,
    output logic                               sample_strobe,
    // samples
    output logic signed [smc_pkg::OUT_W-1:0]   out_x,
    output logic signed [smc_pkg::OUT_W-1:0]   out_y,
    output logic signed [smc_pkg::OUT_W-1:0]   out_z
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // scale a 1/1024 g word to the range, then clamp into the output width
    function automatic logic signed [smc_pkg::OUT_W-1:0] scale_sat(
        input logic signed [smc_pkg::RAW_W:0] v,
        input logic [1:0] rng
    );
        logic signed [smc_pkg::RAW_W:0] s;
        s = v;
        case (rng)
            smc_pkg::RANGE_4G: s = v >>> 1;
            smc_pkg::RANGE_8G: s = v >>> 2;
            default:           s = v;
        endcase
        if (s > $signed({1'b0, smc_pkg::OUT_MAX}))
            scale_sat = smc_pkg::OUT_MAX[smc_pkg::OUT_W-1:0];
        else if (s < $signed({1'b1, smc_pkg::OUT_MIN}))
            scale_sat = smc_pkg::OUT_MIN[smc_pkg::OUT_W-1:0];
        else
            scale_sat = s[smc_pkg::OUT_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // supply pin synchroniser
    // ------------------------------------------------------------------
    logic [2:0] sup_sync;
    logic       sup_level;

    // a change counts only once the second and third stages agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            sup_sync  <= 3'h0;
            sup_level <= 1'b0;
        end else begin
            sup_sync <= {sup_sync[1:0], supply_ok};
            if (sup_sync[1] == sup_sync[2])
                sup_level <= sup_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------
    smc_pkg::smc_state_t state;
    smc_pkg::smc_state_t next_state;
    logic [31:0]         boot_cnt;
    wire                 boot_done = (boot_cnt >= 32'(BOOT_CYC - 1));
    wire                 is_active = (state == smc_pkg::SMC_WAKE)
                                  || (state == smc_pkg::SMC_SLEEP);

    // next mode; a supply loss overrides whatever the host asks for
    always_comb begin
        next_state = state;
        case (state)
            smc_pkg::SMC_OFF:     if (sup_level) next_state = smc_pkg::SMC_BOOT;
            smc_pkg::SMC_BOOT:    if (boot_done) next_state = smc_pkg::SMC_STANDBY;
            smc_pkg::SMC_STANDBY: if (active_req) next_state = smc_pkg::SMC_WAKE;
            smc_pkg::SMC_WAKE:    if (!active_req) next_state = smc_pkg::SMC_STANDBY;
                else if (sleep_req) next_state = smc_pkg::SMC_SLEEP;
            smc_pkg::SMC_SLEEP:   if (!active_req) next_state = smc_pkg::SMC_STANDBY;
                else if (!sleep_req) next_state = smc_pkg::SMC_WAKE;
            default:              next_state = smc_pkg::SMC_OFF;
        endcase
        if (!sup_level)
            next_state = smc_pkg::SMC_OFF;
    end

    // state register and boot timer; the timer only runs during boot
    always_ff @(posedge mclk) begin
        if (srst) begin
            state    <= smc_pkg::SMC_OFF;
            boot_cnt <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            boot_cnt <= (state == smc_pkg::SMC_BOOT) ? boot_cnt + 32'h0000_0001
                                                     : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // sample-rate divider and turn-on timer
    // ------------------------------------------------------------------
    logic [smc_pkg::ODR_W-1:0] odr_cnt;
    logic [31:0]               ton_cnt;
    wire  entering_active = (state == smc_pkg::SMC_STANDBY)
                            && (next_state == smc_pkg::SMC_WAKE);
    wire  odr_tick = is_active && (odr_cnt >= odr_period - smc_pkg::ODR_W'(1));
    wire  [31:0] ton_limit = 32'(smc_pkg::TON_ODR_PERIODS) * 32'(odr_period) + 32'(TON_CYC);

    // divider held at zero outside active: no sampling clock in standby
    always_ff @(posedge mclk) begin
        if (srst) begin
            odr_cnt <= '0;
            ton_cnt <= 32'h0000_0000;
        end else begin
            if (!is_active || odr_tick)
                odr_cnt <= '0;
            else
                odr_cnt <= odr_cnt + smc_pkg::ODR_W'(1);
            if (entering_active)
                ton_cnt <= 32'h0000_0000;
            else if (is_active && ton_cnt < ton_limit)
                ton_cnt <= ton_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // sample path: self-test sum then range scaling
    // ------------------------------------------------------------------
    // the sum keeps one extra bit so an added test stimulus cannot wrap
    wire signed [smc_pkg::RAW_W:0] sum_x = self_test_en ? accel_x + stim_x : accel_x;
    wire signed [smc_pkg::RAW_W:0] sum_y = self_test_en ? accel_y + stim_y : accel_y;
    wire signed [smc_pkg::RAW_W:0] sum_z = self_test_en ? accel_z + stim_z : accel_z;
    wire signed [smc_pkg::OUT_W-1:0] next_x = scale_sat(sum_x, range_sel);
    wire signed [smc_pkg::OUT_W-1:0] next_y = scale_sat(sum_y, range_sel);
    wire signed [smc_pkg::OUT_W-1:0] next_z = scale_sat(sum_z, range_sel);

    // output registers: cleared in off and on entry to active, held in standby
    always_ff @(posedge mclk) begin
        if (srst || state == smc_pkg::SMC_OFF) begin
            out_x <= smc_pkg::OUT_RESET;
            out_y <= smc_pkg::OUT_RESET;
            out_z <= smc_pkg::OUT_RESET;
        end else if (entering_active) begin
            out_x <= smc_pkg::OUT_RESET;
            out_y <= smc_pkg::OUT_RESET;
            out_z <= smc_pkg::OUT_RESET;
        end else if (odr_tick) begin
            out_x <= next_x;
            out_y <= next_y;
            out_z <= next_z;
        end
    end

    // ------------------------------------------------------------------
    // control and status outputs
    // ------------------------------------------------------------------
    // all registered so the pins never glitch on state decode
    always_ff @(posedge mclk) begin
        if (srst) begin
            analog_en         <= 1'b0;
            sample_clk_en     <= 1'b0;
            self_test_drive   <= 1'b0;
            bus_enable        <= 1'b0;
            scl_oe            <= 1'b0;
            subset_reset      <= 1'b0;
            system_mode_state <= smc_pkg::MODE_STANDBY;
            data_trusted      <= 1'b0;
            sample_strobe     <= 1'b0;
        end else begin
            analog_en       <= is_active;
            sample_clk_en   <= is_active;
            self_test_drive <= is_active && self_test_en;
            bus_enable      <= (state == smc_pkg::SMC_STANDBY) || is_active;
            scl_oe          <= 1'b0;
            subset_reset    <= entering_active;
            sample_strobe   <= odr_tick;
            data_trusted    <= is_active && !entering_active
                               && (ton_cnt >= ton_limit);
            case (state)
                smc_pkg::SMC_WAKE:  system_mode_state <= smc_pkg::MODE_WAKE;
                smc_pkg::SMC_SLEEP: system_mode_state <= smc_pkg::MODE_SLEEP;
                default:   system_mode_state <= smc_pkg::MODE_STANDBY;
            endcase
        end
    end

endmodule // smc_mode_ctrl

/* File: testbench/smc_mode_props.sv */
`timescale 1ns/100ps
module smc_mode_props #(
    parameter int TON_CYC = 10
) (
    // clock and reset
    input wire logic                             mclk,
    input wire logic                             srst,
    // controls seen
    input wire logic                             supply_ok,
    input wire logic [smc_pkg::ODR_W-1:0]        odr_period,
    // device outputs
    input wire logic                             analog_en,
    input wire logic                             sample_clk_en,
    input wire logic                             bus_enable,
    input wire logic                             scl_oe,
    input wire logic                             subset_reset,
    input wire logic [1:0]                       system_mode_state,
    input wire logic                             data_trusted,
    input wire logic                             sample_strobe,
    input wire logic signed [smc_pkg::OUT_W-1:0] out_x
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // cycles spent with the analog side up; restarts on every entry
    logic [31:0] act_cnt;
    always_ff @(posedge mclk) begin
        if (srst || !analog_en) begin
            act_cnt <= '0;
        end else begin
            act_cnt <= act_cnt + 32'h0000_0001;
        end
    end

    chk_scl_never: assert property (scl_oe == 1'b0)
        else $error("clock line driven");
    chk_off_quiet: assert property (!supply_ok [*8] |-> !bus_enable && !analog_en)
        else $error("device alive without supply");
    chk_standby_quiet: assert property (bus_enable && system_mode_state == 2'h0
        |-> !analog_en && !sample_clk_en)
        else $error("standby runs analog or clocks");
    chk_active_on: assert property (system_mode_state != 2'h0
        |-> analog_en && sample_clk_en && bus_enable)
        else $error("active mode not fully on");
    chk_subset_entry: assert property (subset_reset |-> !analog_en ##1 ($rose(analog_en) && !subset_reset))
        else $error("subset reset outside entry");
    chk_out_kept: assert property (!$stable(out_x) |-> ##[0:1] (analog_en || !bus_enable))
        else $error("sample changed while idle");
    chk_strobe_active: assert property (sample_strobe |-> sample_clk_en || $past(sample_clk_en))
        else $error("sample without sampling clock");
    chk_trust_bound: assert property (analog_en
        && act_cnt == {8'h00, odr_period} * 2 + TON_CYC + 3 |-> data_trusted)
        else $error("data not trusted in time");
    chk_trust_active: assert property (data_trusted |-> analog_en)
        else $error("trusted outside active");
endmodule // smc_mode_props

bind smc_mode_ctrl smc_mode_props #(.TON_CYC(TON_CYC)) i_props (.mclk, .srst, .supply_ok,
    .odr_period, .analog_en, .sample_clk_en, .bus_enable, .scl_oe, .subset_reset,
    .system_mode_state, .data_trusted, .sample_strobe, .out_x);

/* File: testbench/smc_host_model.sv */
`timescale 1ns/100ps
module smc_host_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // device status and bench command
    input  wire logic bus_enable,
    input  wire logic want_active,
    // mode control bit
    output logic      active_req
);
    // mode write only once the device answers; a lost device loses it too
    always_ff @(posedge mclk) begin
        if (srst) begin
            active_req <= 1'b0;
        end else begin
            active_req <= bus_enable && want_active;
        end
    end
endmodule // smc_host_model

/* File: testbench/tb_smc_mode_ctrl.sv */
`timescale 1ns/100ps
module tb_smc_mode_ctrl;
    logic               mclk = 0, srst = 1, supply_ok = 1, want = 0, sleep_req = 0;
    logic               active_req, self_test_en = 0, analog_en, sample_clk_en;
    logic               self_test_drive, bus_enable, scl_oe, subset_reset;
    logic               data_trusted, sample_strobe;
    logic [1:0]         range_sel = 0, system_mode_state;
    logic signed [15:0] ax = 0, sx = 0;
    logic [23:0]        odr = 24'h00_0004;
    logic signed [11:0] out_x, out_y, out_z;
    int                 n_errors = 0, tests_run = 0;

    always #4 mclk = ~mclk;

    smc_host_model i_host (.mclk, .srst, .bus_enable, .want_active(want), .active_req);
    smc_mode_ctrl #(.BOOT_CYC(20), .TON_CYC(10)) i_dut (.mclk, .srst, .supply_ok,
        .active_req, .sleep_req, .range_sel, .self_test_en, .odr_period(odr),
        .accel_x(ax), .accel_y(-ax), .accel_z(16'h0000), .stim_x(sx),
        .stim_y(sx), .stim_z(sx), .analog_en, .sample_clk_en,
        .self_test_drive, .bus_enable, .scl_oe, .subset_reset, .system_mode_state,
        .data_trusted, .sample_strobe, .out_x, .out_y, .out_z);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // one range per entry; leaving to standby must keep the last sample
    task automatic t_scale(input logic [1:0] r, input logic st, input logic signed [15:0] a,
                           input logic signed [15:0] s);
        logic signed [15:0] add, ex, ey, ez;
        logic [1:0]         sh;
        sh = (r == 2'h3) ? 2'h0 : r;   // spare range code reads as 2 g
        add = st ? s : 16'sh0000;
        ex = (a + add) >>> sh;
        ey = ((-a) + add) >>> sh;
        ez = add >>> sh;
        @(posedge mclk);
        range_sel <= r;
        self_test_en <= st;
        ax <= a;
        sx <= s;
        want <= 1'b1;
        for (int i = 0; i < 60 && subset_reset !== 1'b1; i++) @(negedge mclk);
        check(subset_reset, 1'b1);
        check(out_x, 16'h0000);
        for (int i = 0; i < 60 && sample_strobe !== 1'b1; i++) @(negedge mclk);
        check(sample_strobe, 1'b1);
        check(out_x, ex);
        check(out_y, ey);
        check(out_z, ez);
        check({self_test_drive, system_mode_state}, {st, smc_pkg::MODE_WAKE});
        @(posedge mclk);
        want <= 1'b0;
        repeat (4) @(posedge mclk);
        ax <= ~a;   // a fresh input must not reach a standby sample
        repeat (6) @(negedge mclk);
        check(out_x, ex);
        check({analog_en, sample_clk_en, bus_enable}, 3'b001);
    endtask

    // sleep stays inside active; trust comes by the turn-on time
    task automatic t_sleep();
        @(posedge mclk);
        odr <= 24'h00_0006;
        want <= 1'b1;
        repeat (2 * 6 + 10) @(negedge mclk);
        check(data_trusted, 1'b0);
        repeat (8) @(negedge mclk);
        check(data_trusted, 1'b1);
        @(posedge mclk);
        sleep_req <= 1'b1;
        repeat (4) @(negedge mclk);
        check({analog_en, system_mode_state}, {1'b1, smc_pkg::MODE_SLEEP});
        @(posedge mclk);
        sleep_req <= 1'b0;
        want <= 1'b0;
        repeat (6) @(negedge mclk);
    endtask

    // supply loss shuts everything, bus included
    task automatic t_off();
        @(posedge mclk);
        supply_ok <= 1'b0;
        repeat (10) @(negedge mclk);
        check({analog_en, bus_enable, system_mode_state}, 4'b0000);
        @(posedge mclk);
        supply_ok <= 1'b1;
        for (int i = 0; i < 60 && bus_enable !== 1'b1; i++) @(negedge mclk);
        check({bus_enable, scl_oe}, 2'b10);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // watchdog well past the few hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 60 && bus_enable !== 1'b1; i++) @(negedge mclk);
        check({analog_en, sample_clk_en, bus_enable, system_mode_state}, 5'b00100);
        for (int r = 0; r < 4; r++) t_scale(r[1:0], 1'b0, 16'sd1024, 16'sd0);
        t_scale(2'h1, 1'b1, 16'sd100, 16'sd200);
        t_sleep();
        t_off();
        summarize();
    end
endmodule // tb_smc_mode_ctrl
